// ===== hdl/line_event_pkg.sv
package line_event_pkg;

	localparam int          NUM_LINES   = 19;
	localparam int          PIN_LINES   = 16;
	localparam int          LVD_LINE    = 16;
	localparam int          RTC_LINE    = 17;
	localparam int          USB_LINE    = 18;
	localparam int          DATA_W      = 32;
	localparam int          OFFSET_W    = 10;

	localparam logic [31:0] UNIT_BASE   = 32'h4001_0400;

	localparam logic [9:0]  OFS_IRQ_EN  = 10'h000;
	localparam logic [9:0]  OFS_EVT_EN  = 10'h004;
	localparam logic [9:0]  OFS_RISE_EN = 10'h008;
	localparam logic [9:0]  OFS_FALL_EN = 10'h00C;
	localparam logic [9:0]  OFS_SOFT    = 10'h010;
	localparam logic [9:0]  OFS_PENDING = 10'h014;

	localparam logic [31:0] ENABLE_RESET  = 32'h0000_0000;
	localparam logic [31:0] PENDING_RESET = 32'h0000_0000;
	localparam logic [3:0]  FULL_WORD     = 4'hF;

endpackage : line_event_pkg

// ===== hdl/external_line_unit.sv
// The implementer's own choice: the APB register port.
module external_line_unit #(
	parameter int          LINES = line_event_pkg::NUM_LINES,
	parameter logic [31:0] BASE  = line_event_pkg::UNIT_BASE
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [31:0]          paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [15:0]          pin_line,
	input  wire logic                 low_voltage_detect,
	input  wire logic                 rtc_alarm,
	input  wire logic                 usb_full_speed_wakeup,
	output logic      [LINES-1:0]     line_irq,
	output logic      [LINES-1:0]     line_event,
	output logic                      wake_request
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [LINES-1:0] sync1;
		logic [LINES-1:0] sync2;
		logic [LINES-1:0] prev;
		logic [LINES-1:0] irq_en;
		logic [LINES-1:0] evt_en;
		logic [LINES-1:0] rise_en;
		logic [LINES-1:0] fall_en;
		logic [LINES-1:0] soft_trig;
		logic [LINES-1:0] pending;
		logic [LINES-1:0] irq;
		logic [LINES-1:0] event_pulse;
		logic             wake;
		logic [31:0]      rdata;
		logic             ready;
		logic             slverr;
	} unit_state_t;

	unit_state_t st;
	unit_state_t next_st;

	logic [LINES-1:0] line_raw;
	logic [LINES-1:0] rise;
	logic [LINES-1:0] fall;
	logic [LINES-1:0] hw_trig;
	logic [LINES-1:0] sw_trig;
	logic [LINES-1:0] trig;
	logic [LINES-1:0] pend_clr;
	logic [LINES-1:0] wr_bits;
	logic [9:0]       offset;
	logic             in_window;
	logic             mapped;
	logic             setup;
	logic             access;
	logic             wr;
	logic [31:0]      rd;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_st  = st;
		// Pins arrive already routed by the pin-source selector
		line_raw = {usb_full_speed_wakeup, rtc_alarm, low_voltage_detect, pin_line};

		// Three stages: the first one only feeds the second, so metastable
		// internal sources never reach the edge compare
		next_st.sync1 = line_raw;
		next_st.sync2 = st.sync1;
		next_st.prev  = st.sync2;
		offset    = paddr[line_event_pkg::OFFSET_W-1:0];
		in_window = (paddr[31:line_event_pkg::OFFSET_W] == BASE[31:line_event_pkg::OFFSET_W]);
		mapped    = in_window && (offset == line_event_pkg::OFS_IRQ_EN
			|| offset == line_event_pkg::OFS_EVT_EN
			|| offset == line_event_pkg::OFS_RISE_EN
			|| offset == line_event_pkg::OFS_FALL_EN
			|| offset == line_event_pkg::OFS_SOFT
			|| offset == line_event_pkg::OFS_PENDING);
		setup   = psel && !penable;
		access  = psel && penable && st.ready;
		// A refused transfer never writes
		wr      = access && pwrite && !st.slverr;
		wr_bits = pwdata[LINES-1:0];

		sw_trig  = '0;
		pend_clr = '0;
		if (wr && offset == line_event_pkg::OFS_SOFT) begin
			sw_trig = wr_bits & ~st.soft_trig;
		end
		if (wr && offset == line_event_pkg::OFS_PENDING) begin
			pend_clr = wr_bits;
		end
		trig = hw_trig | sw_trig;

		// Set wins over a clear in the same cycle
		next_st.pending = (st.pending & ~pend_clr) | (trig & st.irq_en);

		if (wr && offset == line_event_pkg::OFS_IRQ_EN) begin
			next_st.irq_en = wr_bits;
		end
		if (wr && offset == line_event_pkg::OFS_EVT_EN) begin
			next_st.evt_en = wr_bits;
		end
		if (wr && offset == line_event_pkg::OFS_RISE_EN) begin
			next_st.rise_en = wr_bits;
		end
		if (wr && offset == line_event_pkg::OFS_FALL_EN) begin
			next_st.fall_en = wr_bits;
		end
		if (wr && offset == line_event_pkg::OFS_SOFT) begin
			next_st.soft_trig = wr_bits;
		end
		// Clearing a flag rearms its soft trigger bit
		next_st.soft_trig = next_st.soft_trig & ~pend_clr;

		next_st.irq         = next_st.pending & next_st.irq_en;
		next_st.event_pulse = trig & st.evt_en;
		next_st.wake        = (|next_st.irq) || (|next_st.event_pulse);

		// ********************************************************
		// APB answer: no wait state, data captured at setup
		// ********************************************************
		rd = '0;
		case (offset)
			line_event_pkg::OFS_IRQ_EN:  rd[LINES-1:0] = st.irq_en;
			line_event_pkg::OFS_EVT_EN:  rd[LINES-1:0] = st.evt_en;
			line_event_pkg::OFS_RISE_EN: rd[LINES-1:0] = st.rise_en;
			line_event_pkg::OFS_FALL_EN: rd[LINES-1:0] = st.fall_en;
			line_event_pkg::OFS_SOFT:    rd[LINES-1:0] = st.soft_trig;
			line_event_pkg::OFS_PENDING: rd[LINES-1:0] = st.pending;
			default:                     rd = '0;
		endcase
		if (!in_window) begin
			rd = '0;
		end
		next_st.ready = setup;
		if (setup) begin
			next_st.rdata  = pwrite ? '0 : rd;
			// Narrow writes are refused rather than half applied
			next_st.slverr = !mapped || (pwrite && pstrb != line_event_pkg::FULL_WORD);
		end else if (access) begin
			next_st.slverr = 1'b0;
		end
	end

	// ************************************************************
	// Per-line edge detectors
	// ************************************************************
	// Each line reads only its own bits, so one line never disturbs another
	for (genvar g = 0; g < LINES; g++) begin : gen_line
		assign rise[g]    = st.sync2[g] && !st.prev[g];
		assign fall[g]    = !st.sync2[g] && st.prev[g];
		assign hw_trig[g] = (rise[g] && st.rise_en[g]) || (fall[g] && st.fall_en[g]);
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st           <= '0;
			st.irq_en    <= line_event_pkg::ENABLE_RESET[LINES-1:0];
			st.evt_en    <= line_event_pkg::ENABLE_RESET[LINES-1:0];
			st.rise_en   <= line_event_pkg::ENABLE_RESET[LINES-1:0];
			st.fall_en   <= line_event_pkg::ENABLE_RESET[LINES-1:0];
			st.soft_trig <= line_event_pkg::ENABLE_RESET[LINES-1:0];
			st.pending   <= line_event_pkg::PENDING_RESET[LINES-1:0];
		end else begin
			st <= next_st;
		end
	end

	assign prdata       = st.rdata;
	assign pready       = st.ready;
	assign pslverr      = st.slverr;
	assign line_irq     = st.irq;
	assign line_event   = st.event_pulse;
	assign wake_request = st.wake;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic acc_wr;
	logic acc_ok;
	assign acc_wr = psel && penable && pwrite;
	assign acc_ok = psel && penable && pready && pwrite && !pslverr;

	a_irq_level: assert property (
		line_irq == (st.pending & st.irq_en))
		else $error("irq output differs from pending and enable");

	// Checked on every line, since the bench picks its line at random
	for (genvar g = 0; g < LINES; g++) begin : gen_edge_chk
		a_rise_event: assert property (@(posedge pclk) disable iff (!presetn)
			($rose(line_raw[g]) && st.rise_en[g] && st.evt_en[g] && !acc_wr) ##1 !acc_wr
			|-> ##2 line_event[g])
			else $error("rising edge gave no event pulse");

		a_fall_event: assert property (@(posedge pclk) disable iff (!presetn)
			($fell(line_raw[g]) && st.fall_en[g] && st.evt_en[g] && !acc_wr) ##1 !acc_wr
			|-> ##2 line_event[g])
			else $error("falling edge gave no event pulse");
	end

	a_hw_pending: assert property (
		((hw_trig & st.irq_en) != '0) |=> ((st.pending & $past(hw_trig & st.irq_en))
			== $past(hw_trig & st.irq_en)))
		else $error("interrupt trigger did not set pending");

	a_event_nopend: assert property (
		(trig[0] && !st.irq_en[0] && !st.pending[0]) |=> !st.pending[0])
		else $error("event only trigger set pending");

	a_soft_trigger: assert property (
		(psel && penable && pready && pwrite && !pslverr
			&& paddr == BASE + 32'(line_event_pkg::OFS_SOFT)
			&& pwdata[0] && !st.soft_trig[0] && st.irq_en[0]) |=> st.pending[0])
		else $error("soft trigger did not set pending");

	a_pend_clear: assert property (
		(psel && penable && pready && pwrite && !pslverr
			&& paddr == BASE + 32'(line_event_pkg::OFS_PENDING)
			&& pwdata[0] && !trig[0]) |=> !st.pending[0])
		else $error("write one did not clear pending");

	a_pend_hold: assert property (
		(st.pending[0] && !(psel && penable && pwrite)) |=> st.pending[0])
		else $error("pending cleared without software");

	a_reserved_zero: assert property (
		prdata[31:LINES] == '0)
		else $error("reserved read bits not zero");

	a_apb_answer: assert property (
		(psel && !penable) ##1 (psel && penable) |-> pready ##1 !pready)
		else $error("access phase not answered in one cycle");

	a_wake_req: assert property (
		(line_irq != '0) |-> wake_request)
		else $error("pending interrupt without wake request");

	a_wake_cause: assert property (
		wake_request |-> (line_irq != '0 || line_event != '0))
		else $error("wake request without a cause");

	a_irq_en_write: assert property (
		(acc_ok && paddr == BASE + 32'(line_event_pkg::OFS_IRQ_EN))
		|=> st.irq_en == $past(pwdata[LINES-1:0]))
		else $error("interrupt enable write not stored");

	a_evt_en_write: assert property (
		(acc_ok && paddr == BASE + 32'(line_event_pkg::OFS_EVT_EN))
		|=> st.evt_en == $past(pwdata[LINES-1:0]))
		else $error("event enable write not stored");

	a_rise_en_write: assert property (
		(acc_ok && paddr == BASE + 32'(line_event_pkg::OFS_RISE_EN))
		|=> st.rise_en == $past(pwdata[LINES-1:0]))
		else $error("rising enable write not stored");

	a_fall_en_write: assert property (
		(acc_ok && paddr == BASE + 32'(line_event_pkg::OFS_FALL_EN))
		|=> st.fall_en == $past(pwdata[LINES-1:0]))
		else $error("falling enable write not stored");

	a_soft_readback: assert property (
		(acc_ok && paddr == BASE + 32'(line_event_pkg::OFS_SOFT))
		|=> st.soft_trig == $past(pwdata[LINES-1:0]))
		else $error("soft trigger write not stored");

	a_clear_rearm: assert property (
		(acc_ok && paddr == BASE + 32'(line_event_pkg::OFS_PENDING))
		|=> (st.soft_trig & $past(pwdata[LINES-1:0])) == '0)
		else $error("pending clear left soft trigger set");

	a_refused_hold: assert property (
		(psel && penable && pready && pslverr)
		|=> $stable(st.irq_en) && $stable(st.evt_en) && $stable(st.rise_en)
			&& $stable(st.fall_en))
		else $error("refused transfer changed an enable");

	a_narrow_refused: assert property (
		(psel && penable && pready && pwrite && pstrb != line_event_pkg::FULL_WORD)
		|-> pslverr)
		else $error("narrow write not refused");

	a_window_refused: assert property (
		(psel && penable && pready
			&& paddr[31:line_event_pkg::OFFSET_W] != BASE[31:line_event_pkg::OFFSET_W])
		|-> pslverr)
		else $error("access outside window not refused");

	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("ready stood longer than one cycle");

	a_write_rdata: assert property (
		(pready && pwrite) |-> prdata == '0)
		else $error("write returned read data");

	a_pend_needs_en: assert property (
		(st.pending & ~$past(st.pending) & ~$past(st.irq_en)) == '0)
		else $error("pending set with interrupt disabled");

	a_event_needs_en: assert property (
		(line_event & ~$past(st.evt_en)) == '0)
		else $error("event pulsed with event disabled");

	c_rise_irq:  cover property (rise[0] && st.rise_en[0] && st.irq_en[0] ##1 line_irq[0]);
	c_soft_trig: cover property (sw_trig != '0);
	c_event:     cover property (line_event[LINES-1]);
	c_error:     cover property (pready && pslverr);
	c_both:      cover property (rise[0] ##[1:8] fall[0]);

endmodule : external_line_unit

// ===== verification/core_sink_model.sv
// ****************************************
// Processor side: counts events and wakes
// ****************************************
module core_sink_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [18:0] line_irq,
	input  wire logic [18:0] line_event,
	input  wire logic        wake_request,
	output int               n_events,
	output int               n_wakes
);
	timeunit 1ns;
	timeprecision 1ps;

	// Requests are levels and need no answer; event pulses and cycles with wake_request high are counted
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_events <= 0;
			n_wakes  <= 0;
		end else begin
			n_events <= n_events + $countones(line_event);
			n_wakes  <= n_wakes + int'(wake_request);
		end
	end
endmodule : core_sink_model

// ===== verification/external_line_event_unit_tb.sv
module external_line_event_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] B = line_event_pkg::UNIT_BASE;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_request;
	logic [31:0] paddr, pwdata, prdata, seed, rd, x;
	logic [3:0]  pstrb;
	logic [18:0] src, line_irq, line_event;
	logic        err, ie;
	int          n_errors, n_compared, n_events, n_wakes, n, m, e0;

	external_line_unit external_line_unit_inst (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_line(src[15:0]), .low_voltage_detect(src[16]), .rtc_alarm(src[17]),
		.usb_full_speed_wakeup(src[18]), .line_irq(line_irq), .line_event(line_event),
		.wake_request(wake_request));
	core_sink_model core_sink_model_inst (.pclk(pclk), .presetn(presetn),
		.line_irq(line_irq), .line_event(line_event), .wake_request(wake_request),
		.n_events(n_events), .n_wakes(n_wakes));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	function automatic logic [31:0] exp_edges(input int mode);
		return (mode == 2) ? 32'h2 : 32'h1;
	endfunction : exp_edges

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One full transfer; the request stands until pready is seen high or 50 cycles pass
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			n_errors++;
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic tally_and_finish();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial begin
		#80000;
		n_errors++;
		tally_and_finish();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, src, n_errors, n_compared} = '0;
		pstrb = 4'hF;
		seed = 32'hdd12;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, B + 4 * i, '0);
			chk("reset value", 32'h0, rd);
		end
		pstrb <= 4'h3;
		apb(1'b1, B, 32'h1);
		pstrb <= 4'hF;
		chk("narrow write error", 32'h1, 32'(err));
		apb(1'b0, B, '0);
		chk("narrow write dropped", 32'h0, rd);
		apb(1'b0, B ^ 32'h0001_0000, '0);
		chk("outside window error", 32'h1, 32'(err));
		chk("outside window data", 32'h0, rd);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			apb(1'b1, B + 4 * i, seed);
			apb(1'b0, B + 4 * i, '0);
			chk("enable readback", seed & 32'h7FFFF, rd);
		end
		apb(1'b0, B + 32'h18, '0);
		chk("unmapped error", 32'h1, 32'(err));
		$display("test registers done");
		// Random line, edge mode cycling rise, fall, both; every other line stays armed too
		for (int t = 0; t < 12; t++) begin
			seed = xs(seed);
			n = seed % 19;
			m = t % 3;
			ie = seed[8];
			x = 32'h1 << n;
			apb(1'b1, B + 32'h8, (m != 1) ? 32'h7FFFF : ~x & 32'h7FFFF);
			apb(1'b1, B + 32'hC, (m != 0) ? 32'h7FFFF : ~x & 32'h7FFFF);
			apb(1'b1, B + 32'h0, ie ? x : 32'h0);
			apb(1'b1, B + 32'h4, x);
			e0 = n_events;
			src[n] <= 1'b1;
			repeat (6) @(posedge pclk);
			src[n] <= 1'b0;
			repeat (6) @(posedge pclk);
			chk("event count", exp_edges(m), 32'(n_events - e0));
			apb(1'b0, B + 32'h14, '0);
			chk("pending", ie ? x : 32'h0, rd);
			chk("irq level", ie ? x : 32'h0, {13'h0, line_irq});
			apb(1'b1, B + 32'h14, 32'h7FFFF);
			apb(1'b0, B + 32'h14, '0);
			chk("pending cleared", 32'h0, rd);
		end
		$display("test edges done");
		apb(1'b1, B + 32'h0, 32'h20000);
		apb(1'b1, B + 32'h10, 32'h20000);
		apb(1'b0, B + 32'h14, '0);
		chk("soft pending", 32'h20000, rd);
		chk("wake seen", 32'h1, 32'(n_wakes > 0));
		$display("test soft trigger done");
		tally_and_finish();
	end
endmodule : external_line_event_unit_tb
